/* tspoc_pkg.sv */
package tspoc_pkg;
    // ************************************************************
    // register map (apb byte addresses, printed offsets are words)
    // ************************************************************
    localparam int ADDR_W = 16;
    localparam logic [15:0] TMR0_CTL1_OFS = 16'hFF7F;
    localparam logic [15:0] TMR1_CTL1_OFS = 16'hFF95;
    localparam logic [15:0] TMR0_RUN_IDX = 16'h0000;
    localparam logic [15:0] TMR1_RUN_IDX = 16'h0001;
    localparam logic [15:0] TMR0_CR1_IDX = 16'h0002;
    localparam logic [15:0] TMR0_CR3_IDX = 16'h0003;
    localparam logic [15:0] TMR1_CR1_IDX = 16'h0004;
    localparam logic [15:0] TMR1_CR3_IDX = 16'h0005;
    localparam logic [15:0] TMR0_PER_IDX = 16'h0006;
    localparam logic [15:0] TMR1_PER_IDX = 16'h0007;
    localparam logic [15:0] CAP_IDX = 16'h0008;
    localparam logic [15:0] IRQ_STAT_IDX = 16'h0009;
    localparam logic [15:0] IRQ_MASK_IDX = 16'h000A;
    localparam logic [15:0] CNT_IDX = 16'h000B;
    localparam logic [15:0] AUX_MODE_IDX = 16'h000C;
    localparam int NUM_WORDS = 13;
    // ************************************************************
    // control register one fields
    // ************************************************************
    localparam int EDGE_START_BIT = 7;
    localparam int GATE_EN_BIT = 5;
    localparam int GATE_POL_BIT = 4;
    localparam int DUAL_OUT_BIT = 3;
    localparam int MODE_HI_BIT = 1;
    localparam int MODE_LO_BIT = 0;
    localparam int AUX_OUT_EN_BIT = 0;
    localparam logic [7:0] CTL0_WMASK = 8'hB8;
    localparam logic [7:0] CTL1_WMASK = 8'h2B;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'hFFFF;
    localparam logic [15:0] PER_RESET = 16'hFFFF;
    // ************************************************************
    // modes and interrupt bits
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_INDEP = 2'h0,
        MODE_SYNC_START = 2'h1,
        MODE_SYNC_CLEAR = 2'h2,
        MODE_BAD = 2'h3
    } tspoc_mode_type;
    localparam int IRQ_T0_MATCH = 0;
    localparam int IRQ_T1_MATCH = 1;
    localparam int IRQ_T0_CAP = 2;
    localparam int IRQ_T1_CAP = 3;
    localparam int IRQ_W = 4;
endpackage

/* tspoc_pwm_gate.sv */
`timescale 1ns/1ps
module tspoc_pwm_gate (
    input wire logic i_pwm,
    input wire logic i_default_level,
    input wire logic i_gate_en,
    input wire logic i_gate_pol,
    input wire logic i_gate_in,
    output logic o_pin
);
    always_comb begin
        if (!i_gate_en) begin
            o_pin = i_pwm;
        end else if (!i_gate_pol) begin
            o_pin = i_gate_in ? i_pwm : i_default_level;
        end else begin
            o_pin = i_gate_in ? ~i_default_level : i_pwm;
        end
    end
endmodule

/* tspoc_timer16.sv */
`timescale 1ns/1ps
module tspoc_timer16 (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_run,
    input wire logic i_start,
    input wire logic i_ext_clear,
    input wire logic [15:0] i_period,
    input wire logic [15:0] i_cmp_a,
    input wire logic [15:0] i_cmp_b,
    input wire logic i_dual,
    output logic [15:0] o_count,
    output logic o_counting,
    output logic o_clear,
    output logic o_match,
    output logic o_pwm_a,
    output logic o_pwm_b
);
    logic counting_reg;
    logic [15:0] count_reg;
    logic wrap;
    assign wrap = counting_reg && (count_reg == i_period);
    assign o_count = count_reg;
    assign o_counting = counting_reg;
    assign o_clear = wrap;
    assign o_match = counting_reg && (count_reg == (i_dual ? i_cmp_b : i_cmp_a));
    assign o_pwm_a = counting_reg && (count_reg < i_cmp_a);
    assign o_pwm_b = counting_reg && i_dual && (count_reg < i_cmp_b);
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            counting_reg <= 1'b0;
        end else if (!i_run) begin
            counting_reg <= 1'b0;
        end else if (i_start) begin
            counting_reg <= 1'b1;
        end
    end
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_reg <= 16'h0000;
        end else if (!i_run || wrap || i_ext_clear) begin
            count_reg <= 16'h0000;
        end else if (counting_reg) begin
            count_reg <= count_reg + 16'h0001;
        end
    end
endmodule

/* tspoc_top.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module tspoc_top (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i_ext_int0,
    input wire logic i_cmp1_event,
    input wire logic i_cmp2_event,
    input wire logic i_gating_timer_output,
    output logic o_timer0_output_a,
    output logic o_timer0_output_b,
    output logic o_timer1_output_a,
    output logic o_timer1_output_b,
    output logic o_timer0_match_interrupt,
    output logic o_timer1_match_interrupt,
    output logic o_irq
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] ctl0_reg;
    logic [7:0] ctl1_reg;
    logic run0_reg;
    logic run1_reg;
    logic aux_mode_reg;
    logic [15:0] cr1_0_reg;
    logic [15:0] cr3_0_reg;
    logic [15:0] cr1_1_reg;
    logic [15:0] cr3_1_reg;
    logic [15:0] per0_reg;
    logic [15:0] per1_reg;
    logic [15:0] cap0_reg;
    logic [15:0] cap1_reg;
    logic [tspoc_pkg::IRQ_W-1:0] stat_reg;
    logic [tspoc_pkg::IRQ_W-1:0] mask_reg;
    logic ext_prev_reg;
    logic armed0_reg;
    logic [31:0] rdata_next;
    logic addr_ok;
    logic wr_en;
    logic rd_en;
    logic [tspoc_pkg::IRQ_W-1:0] irq_events;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic [15:0] word_addr(input logic [15:0] idx);
        word_addr = {idx[13:0], 2'b00};
    endfunction
    function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
        hit = (a == word_addr(idx));
    endfunction

    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && penable && !pwrite && pready;

    // ************************************************************
    // mode and start logic
    // ************************************************************
    tspoc_pkg::tspoc_mode_type mode;
    logic sync_mode;
    logic ext_rise;
    logic start0;
    logic start1;
    logic run1_eff;
    logic t0_counting;
    logic t1_counting;
    logic t0_clear;
    logic t0_match;
    logic t1_match;
    logic [15:0] t0_count;
    logic [15:0] t1_count;
    logic t0_pwm_a;
    logic t0_pwm_b;
    logic t1_pwm_a;
    logic t1_pwm_b;
    logic g0a;
    logic g0b;
    logic g1a;
    logic g1b;
    logic gate_in;

    assign mode = tspoc_pkg::tspoc_mode_type'({ctl1_reg[tspoc_pkg::MODE_HI_BIT],
                                               ctl1_reg[tspoc_pkg::MODE_LO_BIT]});
    assign sync_mode = (mode == tspoc_pkg::MODE_SYNC_START) || (mode == tspoc_pkg::MODE_SYNC_CLEAR);
    assign ext_rise = i_ext_int0 && !ext_prev_reg;
    assign start0 = run0_reg && (!ctl0_reg[tspoc_pkg::EDGE_START_BIT] || armed0_reg && ext_rise);
    assign run1_eff = sync_mode ? run0_reg : run1_reg;
    assign start1 = sync_mode ? start0 : run1_reg;
    assign gate_in = i_gating_timer_output && aux_mode_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= i_ext_int0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            armed0_reg <= 1'b0;
        end else begin
            armed0_reg <= run0_reg && !t0_counting;
        end
    end

    tspoc_timer16 u_tmr0 (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_run(run0_reg),
        .i_start(start0),
        .i_ext_clear(1'b0),
        .i_period(per0_reg),
        .i_cmp_a(cr1_0_reg),
        .i_cmp_b(cr3_0_reg),
        .i_dual(ctl0_reg[tspoc_pkg::DUAL_OUT_BIT]),
        .o_count(t0_count),
        .o_counting(t0_counting),
        .o_clear(t0_clear),
        .o_match(t0_match),
        .o_pwm_a(t0_pwm_a),
        .o_pwm_b(t0_pwm_b)
    );

    tspoc_timer16 u_tmr1 (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_run(run1_eff),
        .i_start(start1),
        .i_ext_clear(mode == tspoc_pkg::MODE_SYNC_CLEAR && t0_clear),
        .i_period(per1_reg),
        .i_cmp_a(cr1_1_reg),
        .i_cmp_b(cr3_1_reg),
        .i_dual(ctl1_reg[tspoc_pkg::DUAL_OUT_BIT]),
        .o_count(t1_count),
        .o_counting(t1_counting),
        .o_clear(),
        .o_match(t1_match),
        .o_pwm_a(t1_pwm_a),
        .o_pwm_b(t1_pwm_b)
    );

    // ************************************************************
    // output gating
    // ************************************************************
    tspoc_pwm_gate u_g0a (
        .i_pwm(t0_pwm_a), .i_default_level(1'b0),
        .i_gate_en(ctl0_reg[tspoc_pkg::GATE_EN_BIT]), .i_gate_pol(ctl0_reg[tspoc_pkg::GATE_POL_BIT]),
        .i_gate_in(gate_in), .o_pin(g0a)
    );
    tspoc_pwm_gate u_g0b (
        .i_pwm(t0_pwm_b), .i_default_level(1'b0),
        .i_gate_en(ctl0_reg[tspoc_pkg::GATE_EN_BIT]), .i_gate_pol(ctl0_reg[tspoc_pkg::GATE_POL_BIT]),
        .i_gate_in(gate_in), .o_pin(g0b)
    );
    tspoc_pwm_gate u_g1a (
        .i_pwm(t1_pwm_a), .i_default_level(1'b0),
        .i_gate_en(ctl1_reg[tspoc_pkg::GATE_EN_BIT]), .i_gate_pol(ctl0_reg[tspoc_pkg::GATE_POL_BIT]),
        .i_gate_in(gate_in), .o_pin(g1a)
    );
    tspoc_pwm_gate u_g1b (
        .i_pwm(t1_pwm_b), .i_default_level(1'b0),
        .i_gate_en(ctl1_reg[tspoc_pkg::GATE_EN_BIT]), .i_gate_pol(ctl0_reg[tspoc_pkg::GATE_POL_BIT]),
        .i_gate_in(gate_in), .o_pin(g1b)
    );

    // second pin idle in single mode
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_timer0_output_a <= 1'b0;
            o_timer0_output_b <= 1'b0;
            o_timer1_output_a <= 1'b0;
            o_timer1_output_b <= 1'b0;
            o_timer0_match_interrupt <= 1'b0;
            o_timer1_match_interrupt <= 1'b0;
        end else begin
            o_timer0_output_a <= g0a;
            o_timer0_output_b <= ctl0_reg[tspoc_pkg::DUAL_OUT_BIT] && g0b;
            o_timer1_output_a <= g1a;
            o_timer1_output_b <= ctl1_reg[tspoc_pkg::DUAL_OUT_BIT] && g1b;
            o_timer0_match_interrupt <= t0_match;
            o_timer1_match_interrupt <= t1_match;
        end
    end

    // ************************************************************
    // capture
    // ************************************************************
    // capture sources per timer
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cap0_reg <= 16'h0000;
            cap1_reg <= 16'h0000;
        end else begin
            if (i_cmp2_event || ext_rise) begin
                cap0_reg <= t0_count;
            end
            if (i_cmp1_event) begin
                cap1_reg <= t1_count;
            end
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************
    // reset clears control one
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctl0_reg <= tspoc_pkg::CTL_RESET;
            ctl1_reg <= tspoc_pkg::CTL_RESET;
            run0_reg <= 1'b0;
            run1_reg <= 1'b0;
            aux_mode_reg <= 1'b0;
            mask_reg <= '0;
        end else if (wr_en) begin
            if (hit(paddr, tspoc_pkg::TMR0_CTL1_OFS)) ctl0_reg <= pwdata[7:0] & tspoc_pkg::CTL0_WMASK;
            if (hit(paddr, tspoc_pkg::TMR1_CTL1_OFS)) ctl1_reg <= pwdata[7:0] & tspoc_pkg::CTL1_WMASK;
            if (hit(paddr, tspoc_pkg::TMR0_RUN_IDX)) run0_reg <= pwdata[0];
            if (hit(paddr, tspoc_pkg::TMR1_RUN_IDX)) run1_reg <= pwdata[0];
            if (hit(paddr, tspoc_pkg::AUX_MODE_IDX)) aux_mode_reg <= pwdata[tspoc_pkg::AUX_OUT_EN_BIT];
            if (hit(paddr, tspoc_pkg::IRQ_MASK_IDX)) mask_reg <= pwdata[tspoc_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cr1_0_reg <= tspoc_pkg::CMP_RESET;
            cr3_0_reg <= tspoc_pkg::CMP_RESET;
            cr1_1_reg <= tspoc_pkg::CMP_RESET;
            cr3_1_reg <= tspoc_pkg::CMP_RESET;
            per0_reg <= tspoc_pkg::PER_RESET;
            per1_reg <= tspoc_pkg::PER_RESET;
        end else if (wr_en) begin
            if (hit(paddr, tspoc_pkg::TMR0_CR1_IDX)) cr1_0_reg <= pwdata[15:0];
            if (hit(paddr, tspoc_pkg::TMR0_CR3_IDX)) cr3_0_reg <= pwdata[15:0];
            if (hit(paddr, tspoc_pkg::TMR1_CR1_IDX)) cr1_1_reg <= pwdata[15:0];
            if (hit(paddr, tspoc_pkg::TMR1_CR3_IDX)) cr3_1_reg <= pwdata[15:0];
            if (hit(paddr, tspoc_pkg::TMR0_PER_IDX)) per0_reg <= pwdata[15:0];
            if (hit(paddr, tspoc_pkg::TMR1_PER_IDX)) per1_reg <= pwdata[15:0];
        end
    end

    // ************************************************************
    // interrupts: sticky, read clears, set wins
    // ************************************************************
    assign irq_events = {i_cmp1_event, i_cmp2_event || ext_rise, t1_match, t0_match};

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stat_reg <= '0;
        end else if (rd_en && hit(paddr, tspoc_pkg::IRQ_STAT_IDX)) begin
            stat_reg <= (stat_reg & ~prdata[tspoc_pkg::IRQ_W-1:0]) | irq_events;
        end else begin
            stat_reg <= stat_reg | irq_events;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(stat_reg & mask_reg);
        end
    end

    // ************************************************************
    // apb read and answer
    // ************************************************************
    always_comb begin
        rdata_next = 32'h0000_0000;
        addr_ok = 1'b1;
        if (hit(paddr, tspoc_pkg::TMR0_CTL1_OFS)) rdata_next[7:0] = ctl0_reg;
        else if (hit(paddr, tspoc_pkg::TMR1_CTL1_OFS)) rdata_next[7:0] = ctl1_reg;
        else if (hit(paddr, tspoc_pkg::TMR0_RUN_IDX)) rdata_next = {30'h0, t0_counting, run0_reg};
        else if (hit(paddr, tspoc_pkg::TMR1_RUN_IDX)) rdata_next = {30'h0, t1_counting, run1_reg};
        else if (hit(paddr, tspoc_pkg::TMR0_CR1_IDX)) rdata_next[15:0] = cr1_0_reg;
        else if (hit(paddr, tspoc_pkg::TMR0_CR3_IDX)) rdata_next[15:0] = cr3_0_reg;
        else if (hit(paddr, tspoc_pkg::TMR1_CR1_IDX)) rdata_next[15:0] = cr1_1_reg;
        else if (hit(paddr, tspoc_pkg::TMR1_CR3_IDX)) rdata_next[15:0] = cr3_1_reg;
        else if (hit(paddr, tspoc_pkg::TMR0_PER_IDX)) rdata_next[15:0] = per0_reg;
        else if (hit(paddr, tspoc_pkg::TMR1_PER_IDX)) rdata_next[15:0] = per1_reg;
        else if (hit(paddr, tspoc_pkg::CAP_IDX)) rdata_next = {cap1_reg, cap0_reg};
        else if (hit(paddr, tspoc_pkg::IRQ_STAT_IDX)) rdata_next[tspoc_pkg::IRQ_W-1:0] = stat_reg;
        else if (hit(paddr, tspoc_pkg::IRQ_MASK_IDX)) rdata_next[tspoc_pkg::IRQ_W-1:0] = mask_reg;
        else if (hit(paddr, tspoc_pkg::CNT_IDX)) rdata_next = {t1_count, t0_count};
        else if (hit(paddr, tspoc_pkg::AUX_MODE_IDX)) rdata_next[tspoc_pkg::AUX_OUT_EN_BIT] = aux_mode_reg;
        else addr_ok = 1'b0;
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            prdata <= pwrite ? 32'h0000_0000 : rdata_next;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    no_edge_hold_a: assert property (run0_reg && !t0_counting && !ext_rise
        && ctl0_reg[tspoc_pkg::EDGE_START_BIT] |=> !t0_counting) else $error("timer0 started without edge");
    soft_start_a: assert property ($rose(run0_reg) && !ctl0_reg[tspoc_pkg::EDGE_START_BIT] |=> t0_counting)
        else $error("timer0 did not start on run");
    stop_clear_a: assert property (!run0_reg |=> t0_count == 16'h0000)
        else $error("counter not cleared on stop");
    sync_start_a: assert property (sync_mode && $rose(t0_counting) |-> $rose(t1_counting))
        else $error("second timer lag in sync mode");
    match_one_a: assert property (t0_counting && !ctl0_reg[tspoc_pkg::DUAL_OUT_BIT] && t0_count == cr1_0_reg
        |=> o_timer0_match_interrupt) else $error("no interrupt on compare one match");
    match_sel_a: assert property (t0_counting && ctl0_reg[tspoc_pkg::DUAL_OUT_BIT] && t0_count == cr3_0_reg
        |=> o_timer0_match_interrupt) else $error("no interrupt on compare three match");
    gate_low_a: assert property (ctl0_reg[tspoc_pkg::GATE_EN_BIT] && !ctl0_reg[tspoc_pkg::GATE_POL_BIT]
        && !gate_in |=> !o_timer0_output_a) else $error("gated output not default");
    gate_inv_a: assert property (ctl0_reg[tspoc_pkg::GATE_EN_BIT] && ctl0_reg[tspoc_pkg::GATE_POL_BIT]
        && gate_in |=> o_timer0_output_a) else $error("gated output not inverted default");
    single_pin_a: assert property (!ctl0_reg[tspoc_pkg::DUAL_OUT_BIT] |=> !o_timer0_output_b)
        else $error("second pin active in single mode");
    cap1_src_a: assert property (i_cmp1_event |=> cap1_reg == $past(t1_count))
        else $error("timer1 capture wrong");

    start_c: cover property ($rose(t0_counting));
    edge_start_c: cover property (ctl0_reg[tspoc_pkg::EDGE_START_BIT] && $rose(t0_counting));
    sync_clear_c: cover property (mode == tspoc_pkg::MODE_SYNC_CLEAR && t0_clear);
    irq_c: cover property ($rose(o_irq));
endmodule

/* tspoc_top_tb.sv */
`timescale 1ns/1ps
module tspoc_top_tb;
    // ****************************************
    // bench signals and register addresses
    // ****************************************
    function automatic logic [15:0] ba(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction
    localparam logic [15:0] A_CTL0 = ba(tspoc_pkg::TMR0_CTL1_OFS);
    localparam logic [15:0] A_CTL1 = ba(tspoc_pkg::TMR1_CTL1_OFS);
    localparam logic [15:0] A_RUN0 = ba(tspoc_pkg::TMR0_RUN_IDX);
    localparam logic [15:0] A_RUN1 = ba(tspoc_pkg::TMR1_RUN_IDX);
    localparam logic [15:0] A_CR10 = ba(tspoc_pkg::TMR0_CR1_IDX);
    localparam logic [15:0] A_CR30 = ba(tspoc_pkg::TMR0_CR3_IDX);
    localparam logic [15:0] A_CR11 = ba(tspoc_pkg::TMR1_CR1_IDX);
    localparam logic [15:0] A_CR31 = ba(tspoc_pkg::TMR1_CR3_IDX);
    localparam logic [15:0] A_PER0 = ba(tspoc_pkg::TMR0_PER_IDX);
    localparam logic [15:0] A_PER1 = ba(tspoc_pkg::TMR1_PER_IDX);
    localparam logic [15:0] A_STAT = ba(tspoc_pkg::IRQ_STAT_IDX);
    localparam logic [15:0] A_MASK = ba(tspoc_pkg::IRQ_MASK_IDX);
    localparam logic [15:0] A_CNT = ba(tspoc_pkg::CNT_IDX);
    localparam logic [15:0] A_AUX = ba(tspoc_pkg::AUX_MODE_IDX);
    logic clk, rst_b, psel, penable, pwrite, ext, c1, c2, gate, pready, pslverr, err, irq;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [5:0] obs;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int c;
    tspoc_top tspoc_top_inst (.i_core_clk(clk), .i_rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_ext_int0(ext),
        .i_cmp1_event(c1), .i_cmp2_event(c2), .i_gating_timer_output(gate), .o_timer0_output_a(obs[0]),
        .o_timer0_output_b(obs[1]), .o_timer1_output_a(obs[2]), .o_timer1_output_b(obs[3]),
        .o_timer0_match_interrupt(obs[4]), .o_timer1_match_interrupt(obs[5]), .o_irq(irq));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic final_report();
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cnt_hi(input int sel, input int n);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            if (obs[sel] === 1'b1) c++;
        end
    endtask
    task automatic pulse(input int sel);
        if (sel == 0) c1 <= 1'b1; else if (sel == 1) c2 <= 1'b1; else ext <= 1'b1;
        @(posedge clk);
        c1 <= 1'b0;
        c2 <= 1'b0;
        ext <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic run_cfg(input logic [7:0] ctl, input logic g, input int sel, input int exp);
        apb(1'b1, A_RUN0, 32'h0);
        apb(1'b1, A_CTL0, {24'h0, ctl});
        gate <= g;
        apb(1'b1, A_RUN0, 32'h1);
        repeat (4) @(posedge clk);
        cnt_hi(sel, 20);
        chk(c, exp);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_reset();
        apb(1'b0, A_CTL0, 32'h0); chk(q, 32'h0);
        apb(1'b0, A_CTL1, 32'h0); chk(q, 32'h0);
        apb(1'b0, 16'h0034, 32'h0); chk({err, q[30:0]}, {1'b1, 31'h0});
        apb(1'b1, A_CTL0, 32'hFF); apb(1'b0, A_CTL0, 32'h0); chk(q, {24'h0, tspoc_pkg::CTL0_WMASK});
        apb(1'b1, A_CTL1, 32'h2A); apb(1'b0, A_CTL1, 32'h0); chk(q, 32'h2A);
        apb(1'b1, A_CTL0, 32'h0);
        apb(1'b1, A_CTL1, 32'h0);
    endtask
    task automatic s_start();
        apb(1'b1, A_PER0, 32'h9);
        pulse(2);
        apb(1'b0, A_CNT, 32'h0); chk(q, 32'h0);
        apb(1'b1, A_RUN0, 32'h1);
        apb(1'b0, A_CNT, 32'h0); chk(q[15:0] != 16'h0, 1);
        apb(1'b1, A_RUN0, 32'h0);
        apb(1'b0, A_CNT, 32'h0); chk(q, 32'h0);
        apb(1'b1, A_CTL0, 32'h80);
        apb(1'b1, A_RUN0, 32'h1);
        repeat (5) @(posedge clk);
        apb(1'b0, A_CNT, 32'h0); chk(q, 32'h0);
        pulse(2);
        apb(1'b0, A_CNT, 32'h0); chk(q[15:0] != 16'h0, 1);
        apb(1'b1, A_RUN0, 32'h0);
        apb(1'b1, A_CTL0, 32'h0);
    endtask
    task automatic s_gate();
        apb(1'b1, A_AUX, 32'h1);
        apb(1'b1, A_CR10, 32'h5);
        apb(1'b1, A_CR30, 32'h3);
        run_cfg(8'h00, 1'b0, 0, 10);
        run_cfg(8'h20, 1'b0, 0, 0);
        run_cfg(8'h20, 1'b1, 0, 10);
        run_cfg(8'h30, 1'b1, 0, 20);
        run_cfg(8'h30, 1'b0, 0, 10);
        run_cfg(8'h00, 1'b0, 1, 0);
        run_cfg(8'h08, 1'b0, 1, 6);
        apb(1'b1, A_RUN0, 32'h0);
        apb(1'b1, A_CR10, 32'hFFFF);
        run_cfg(8'h00, 1'b0, 4, 0);
        run_cfg(8'h08, 1'b0, 4, 2);
        apb(1'b1, A_RUN0, 32'h0);
        apb(1'b1, A_CTL0, 32'h0);
    endtask
    task automatic s_sync();
        apb(1'b1, A_PER1, 32'h1F);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, A_CTL1, m);
            apb(1'b1, A_RUN0, 32'h1);
            repeat (12) @(posedge clk);
            apb(1'b0, A_CNT, 32'h0); chk(q[15:0] != 16'h0, 1);
            chk(q[31:16], (m == 0) ? 16'h0 : (m == 1) ? q[15:0] + 16'h000A : q[15:0]);
            apb(1'b1, A_RUN0, 32'h0);
            apb(1'b0, A_CNT, 32'h0); chk(q, 32'h0);
        end
        apb(1'b1, A_PER1, 32'h9);
        apb(1'b1, A_CR11, 32'h5);
        apb(1'b1, A_CR31, 32'h3);
        apb(1'b1, A_CTL1, 32'h8);
        apb(1'b1, A_RUN1, 32'h1);
        repeat (4) @(posedge clk);
        cnt_hi(2, 20); chk(c, 10);
        cnt_hi(3, 20); chk(c, 6);
        cnt_hi(5, 20); chk(c, 2);
        apb(1'b1, A_RUN1, 32'h0);
        apb(1'b1, A_CTL1, 32'h0);
    endtask
    task automatic s_irq();
        apb(1'b1, A_RUN0, 32'h1);
        apb(1'b1, A_RUN1, 32'h1);
        apb(1'b1, A_MASK, 32'hC);
        apb(1'b0, A_STAT, 32'h0);
        for (int s = 0; s < 3; s++) begin
            pulse(s);
            chk(irq, 1);
            apb(1'b0, A_STAT, 32'h0); chk(q[3:2], (s == 0) ? 2'h2 : 2'h1);
            repeat (2) @(posedge clk);
            chk(irq, 0);
        end
        apb(1'b1, A_MASK, 32'h0);
        pulse(0);
        chk(irq, 0);
        apb(1'b1, A_RUN0, 32'h0);
        apb(1'b1, A_RUN1, 32'h0);
    endtask
    // ****************************************
    // clock, timeout and main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        {rst_b, psel, penable, pwrite, ext, c1, c2, gate} = 8'h00;
        paddr = 16'h0000;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        s_reset();
        s_start();
        s_gate();
        s_sync();
        s_irq();
        final_report();
    end
endmodule
